// ---- core/ssdr_core.sv ----
// Serial diagnostic status responder: latches fault events, answers
// fault and communication status reads over a 16-bit serial link.
// Assumes the host is link master; the serial clock is its own domain.
//
// Behaviour
// - Unknown control code sets the serial command error flag, bit 7.
// - Fault read answers header 001000 in bits 14..9, flags low byte.
// - Flags of a response clear once the host has read it.
// - Bit 7 reports supply current short or open.
// - Bit 6 reports overcurrent.
// - Bits 4,3,2 report logic overvolt, second overvolt, pump low.
// - Bit 1 reports overtemperature.
// - Bit 0 reports calibration memory CRC mismatch.
// - Comm read answers 010000 header and command error in bit 7.
// - Events during a transfer go to a shadow register.
// - After the transfer the shadow moves into the status register.
// - Fault output stays high while shadowed news is unread.
// - A read reports only events before its select falling edge.
// - Gate drivers halt on certain latched faults.
// - Valid transfer is exactly 16 clocks with select held low.
// - Input register updates on select rise only if count and key valid.
`timescale 1ns/1ps
module ssdr_core
    import ssdr_pkg::*;
(
    // System clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       clk_en_in,
    // Serial link, host drives clock and select
    input  wire logic       sck_in,
    input  wire logic       cs_n_in,
    input  wire logic       sdi_in,
    output logic            sdo_out,
    output logic            sdo_oe_n_out,
    // Detector levels
    input  wire logic [7:0] detect_in,
    // Status outputs
    output logic            fault_out,
    output logic            gate_halt_out,
    output logic [15:0]     last_command_out
);
    import ssdr_pkg::*;

    // ------------------------------------------------------------
    // Link domain: shift in on rising, out on falling sck
    // ------------------------------------------------------------
    logic [15:0]      rx_shift_reg;
    logic [CNT_W-1:0] rx_count_reg;
    logic [15:0]      tx_shift_reg;
    logic             tx_bit_reg;
    logic [15:0]      tx_word_sync;

    // Frame reset is the select line itself, so nothing waits on sck
    always_ff @(posedge sck_in or posedge cs_n_in)
    begin
        if (cs_n_in)
            rx_count_reg <= '0;
        else if (rx_count_reg != 5'h1F)
            rx_count_reg <= rx_count_reg + 5'h01;
    end

    always_ff @(posedge sck_in)
    begin
        rx_shift_reg <= {rx_shift_reg[14:0], sdi_in};
    end

    // First bit presented at select fall, rest on falling sck
    // First falling edge loads the whole word, so the MSB stays on the
    // pin for the first rising edge; shifting here would drop it
    always_ff @(negedge sck_in or posedge cs_n_in)
    begin
        if (cs_n_in)
            tx_shift_reg <= 16'h0000;
        else if (rx_count_reg != 5'h00)
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
        else
            tx_shift_reg <= tx_word_sync;
    end

    always_ff @(negedge sck_in or posedge cs_n_in)
    begin
        if (cs_n_in)
            tx_bit_reg <= 1'b0;
        else
            tx_bit_reg <= 1'b1;
    end

    // Word is stable for whole frame, loaded while select was high
    // Limitation: host must keep the lead time before the first falling
    // sck, so the system side has seen select fall and frozen the word
    assign sdo_out      = tx_bit_reg ? tx_shift_reg[15] : tx_word_sync[15];
    assign sdo_oe_n_out = cs_n_in;

    // ------------------------------------------------------------
    // Crossing of select into system domain
    // ------------------------------------------------------------
    logic cs_level;
    logic cs_prev_reg;

    ssdr_sync u_cs_sync
    (
        .clk_in         (clk_in),
        .reset_in       (reset_in),
        .enable_in      (clk_en_in),
        .reset_value_in (1'b1),
        .async_in       (cs_n_in),
        .level_out      (cs_level)
    );

    wire cs_fall = cs_prev_reg & ~cs_level;
    wire cs_rise = ~cs_prev_reg & cs_level;

    // Received word and count are static once select is high again
    // Both are captured on the select rising edge in the link domain and
    // read here only on cs_rise, several clocks later, when they are quiet
    logic [15:0] rx_word_reg;
    logic [4:0]  rx_cnt_cap_reg;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    function automatic logic cmd_known(input logic [5:0] code);
        cmd_known = (code == CMD_MODE) || (code == CMD_GAIN) ||
                    (code == CMD_UNUSED3) || (code == CMD_FAULT_RD) ||
                    (code == CMD_COMM_RD) || (code == CMD_SPARE_RD);
    endfunction

    wire [5:0] rx_code    = rx_word_reg[CTRL_HI:CTRL_LO];
    wire       count_ok   = (rx_cnt_cap_reg == FRAME_COUNT);
    wire       key_ok     = cmd_known(rx_code);
    wire       cmd_accept = cs_rise && count_ok && key_ok;
    wire       cmd_bad    = cs_rise && count_ok && !key_ok;

    // ------------------------------------------------------------
    // Flags, shadow and status
    // ------------------------------------------------------------
    logic [7:0]    detect_sync1_reg;
    logic [7:0]    detect_sync2_reg;
    logic [7:0]    detect_sync3_reg;
    logic [7:0]    status_reg;
    logic [7:0]    shadow_reg;
    logic          comm_err_reg;
    logic          comm_shadow_reg;
    logic          in_frame_reg;
    logic [7:0]    reply_kind_reg;
    logic [15:0]   tx_word_reg;
    logic [15:0]   last_cmd_reg;
    ssdr_state_t   state_reg;
    ssdr_state_t   state_next;

    // Detector levels agree across two stages before counting
    wire [7:0] det_stable = detect_sync3_reg & detect_sync2_reg & FAULT_MASK;

    wire reading_fault = (reply_kind_reg == HDR_FAULT);
    wire reading_comm  = (reply_kind_reg == HDR_COMM);
    wire frame_end     = cs_rise && (state_reg == SSDR_SHIFT);
    // Select fall counts as framed, so an event in that cycle is shadowed
    // rather than landing in status after the word has frozen
    wire framed        = in_frame_reg | cs_fall;

    // Events go to shadow while framed, status otherwise and at frame_end
    wire [7:0] status_next = frame_end
        ? ((reading_fault && count_ok ? FLAGS_RESET : status_reg)
           | shadow_reg | det_stable)
        : (framed ? status_reg : (status_reg | det_stable));
    wire [7:0] shadow_next = frame_end ? FLAGS_RESET
        : (framed ? (shadow_reg | det_stable) : shadow_reg);

    wire comm_next = frame_end
        ? ((reading_comm && count_ok ? 1'b0 : comm_err_reg) | comm_shadow_reg | cmd_bad)
        : comm_err_reg;
    wire comm_shadow_next = 1'b0;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SSDR_IDLE:  if (cs_fall) state_next = SSDR_SHIFT;
            SSDR_SHIFT: if (cs_rise) state_next = SSDR_DONE;
            SSDR_DONE:  state_next = SSDR_IDLE;
            default:    state_next = SSDR_IDLE;
        endcase
    end

    // Next reply selected from the accepted command
    wire [7:0] kind_next = !cmd_accept ? HDR_IDLE
        : (rx_code == CMD_FAULT_RD) ? HDR_FAULT
        : (rx_code == CMD_COMM_RD)  ? HDR_COMM
        : (rx_code == CMD_SPARE_RD) ? HDR_SPARE
        : HDR_ECHO;

    // Word prepared while select is high; read at the next frame
    // Fault word follows status_next, so the frozen word equals status
    wire [15:0] word_next =
        (reply_kind_reg == HDR_FAULT) ? {HDR_FAULT, status_next}
        : (reply_kind_reg == HDR_COMM) ? {HDR_COMM, comm_err_reg, 7'h00}
        : {reply_kind_reg, 8'h00};

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            detect_sync1_reg <= 8'h00;
            detect_sync2_reg <= 8'h00;
            detect_sync3_reg <= 8'h00;
        end
        else if (clk_en_in)
        begin
            detect_sync1_reg <= detect_in;
            detect_sync2_reg <= detect_sync1_reg;
            detect_sync3_reg <= detect_sync2_reg;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_reg       <= SSDR_IDLE;
            cs_prev_reg     <= 1'b1;
            in_frame_reg    <= 1'b0;
            status_reg      <= FLAGS_RESET;
            shadow_reg      <= FLAGS_RESET;
            comm_err_reg    <= 1'b0;
            comm_shadow_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            state_reg       <= state_next;
            cs_prev_reg     <= cs_level;
            in_frame_reg    <= (in_frame_reg | cs_fall) & ~cs_rise;
            status_reg      <= status_next;
            shadow_reg      <= shadow_next;
            comm_err_reg    <= comm_next;
            comm_shadow_reg <= comm_shadow_next;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            reply_kind_reg <= HDR_IDLE;
            last_cmd_reg   <= 16'h0000;
            tx_word_reg    <= {HDR_IDLE, 8'h00};
        end
        else if (clk_en_in)
        begin
            // Bad-count frames leave the pending reply untouched; unknown codes set it idle
            if (cmd_accept || cmd_bad)
                reply_kind_reg <= kind_next;
            if (cmd_accept)
                last_cmd_reg <= rx_word_reg;
            if (!in_frame_reg && !cs_fall)
                tx_word_reg <= word_next;
        end
    end

    // Sampled by the link only while select is low and the word is frozen
    assign tx_word_sync = tx_word_reg;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic fault_reg;
    logic halt_reg;

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            fault_reg <= 1'b0;
            halt_reg  <= 1'b0;
        end
        else if (clk_en_in)
        begin
            fault_reg <= (|status_reg) | (|shadow_reg);
            halt_reg  <= |((status_reg | shadow_reg) & HALT_MASK);
        end
    end

    assign fault_out        = fault_reg;
    assign gate_halt_out    = halt_reg;
    assign last_command_out = last_cmd_reg;

    // Link-side capture of the finished frame on select rise. The count
    // clears on this same edge; its reset-to-output delay covers the hold.
    always_ff @(posedge cs_n_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rx_word_reg    <= 16'h0000;
            rx_cnt_cap_reg <= 5'h00;
        end
        else
        begin
            rx_word_reg    <= rx_shift_reg;
            rx_cnt_cap_reg <= rx_count_reg;
        end
    end
endmodule

// ---- core/ssdr_pkg.sv ----
// Constants for the serial diagnostic status responder.
// Shared by the main block and its input synchroniser.
package ssdr_pkg;

    // --------------------------------------------------------------
    // Frame layout
    // --------------------------------------------------------------
    localparam int          FRAME_BITS    = 16;
    localparam int          CNT_W         = 5;
    localparam logic [4:0]  FRAME_COUNT   = 5'h10;
    localparam int          CTRL_HI       = 15;
    localparam int          CTRL_LO       = 10;

    // --------------------------------------------------------------
    // Command codes in bits 15..10 of the received word
    // --------------------------------------------------------------
    localparam logic [5:0]  CMD_MODE      = 6'h01;
    localparam logic [5:0]  CMD_GAIN      = 6'h02;
    localparam logic [5:0]  CMD_UNUSED3   = 6'h03;
    localparam logic [5:0]  CMD_FAULT_RD  = 6'h08;
    localparam logic [5:0]  CMD_COMM_RD   = 6'h10;
    localparam logic [5:0]  CMD_SPARE_RD  = 6'h18;

    // --------------------------------------------------------------
    // Response headers, bits 15..8 of the transmitted word
    // --------------------------------------------------------------
    localparam logic [7:0]  HDR_IDLE      = 8'h02;
    localparam logic [7:0]  HDR_ECHO      = 8'h04;
    localparam logic [7:0]  HDR_FAULT     = 8'h10;
    localparam logic [7:0]  HDR_COMM      = 8'h20;
    localparam logic [7:0]  HDR_SPARE     = 8'h30;

    // --------------------------------------------------------------
    // Fault flag positions in the low byte
    // --------------------------------------------------------------
    localparam int          FLG_SUPPLY_I  = 7;
    localparam int          FLG_OVERCUR   = 6;
    localparam int          FLG_LOGIC_OV  = 4;
    localparam int          FLG_SECOND_OV = 3;
    localparam int          FLG_PUMP_LOW  = 2;
    localparam int          FLG_THERMAL   = 1;
    localparam int          FLG_CALIB_CRC = 0;
    localparam int          FLG_CMD_ERR   = 7;
    localparam logic [7:0]  FAULT_MASK    = 8'hDF;
    localparam logic [7:0]  HALT_MASK     = 8'h5C;
    localparam logic [7:0]  FLAGS_RESET   = 8'h00;

    // --------------------------------------------------------------
    // Receive-side states
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        SSDR_IDLE  = 2'b00,
        SSDR_SHIFT = 2'b01,
        SSDR_DONE  = 2'b11
    } ssdr_state_t;

endpackage

// ---- core/ssdr_sync.sv ----
// Three-stage synchroniser with agreement check for one level.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/1ps
module ssdr_sync
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic enable_in,
    input  wire logic reset_value_in,
    // Level
    input  wire logic async_in,
    output logic      level_out
);
    import ssdr_pkg::*;

    logic [2:0] stage_reg;
    logic       level_reg;
    wire        agree = (stage_reg[2] == stage_reg[1]);

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            stage_reg <= 3'h7;
        else if (enable_in)
            stage_reg <= {stage_reg[1:0], async_in};
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            level_reg <= 1'b1;
        else if (enable_in && agree)
            level_reg <= stage_reg[2];
    end

    assign level_out = level_reg;
endmodule

// ---- verification/ssdr_core_bench.sv ----
// Bench for the responder: frames through the host model.
// Assumes the checker is bound in; clk_en_in is held high.
`timescale 1ns/1ps
module ssdr_core_bench;
    import ssdr_pkg::*;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [7:0]  detect = 8'h00;
    logic        start = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [4:0]  pulses = 5'h10;
    logic        sck, cs_n, sdi, sdo, oe_n, line, done, fault, halt;
    logic [15:0] rx, last_cmd, got;
    logic [7:0]  m;
    int          mismatches = 0;
    int          checked = 0;
    int          b;
    logic [15:0] cmds [9] = '{16'h0400, 16'h0800, 16'h0C00, 16'h6000, 16'h4000,
                              16'h3C00, 16'h4000, 16'h4000, 16'h4000};
    logic [15:0] resp [9] = '{16'h1000, 16'h0400, 16'h0400, 16'h0400, 16'h3000,
                              16'h2000, 16'h0200, 16'h2080, 16'h2000};
    always #5 clk_in = ~clk_in;
    // Released line shows the inverse, never a stale bit
    assign line = oe_n ? ~sdo : sdo;
    ssdr_core DUT (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(1'b1), .sck_in(sck),
        .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(oe_n), .detect_in(detect),
        .fault_out(fault), .gate_halt_out(halt), .last_command_out(last_cmd));
    ssdr_host_model host (.clk_in(clk_in), .start_in(start), .word_in(word),
        .pulses_in(pulses), .done_out(done), .rx_out(rx), .sdo_in(line), .sck_out(sck),
        .cs_n_out(cs_n), .sdi_out(sdi));
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [15:0] w, input logic [4:0] n);
        int k;
        word <= w;
        pulses <= n;
        start <= 1'b1;
        for (k = 0; k < 4000 && done !== 1'b1; k++)
            @(posedge clk_in);
        if (done !== 1'b1)
        begin
            mismatches++;
            conclude();
        end
        got = rx;
        start <= 1'b0;
        for (k = 0; k < 9 && done !== 1'b0; k++)
            @(posedge clk_in);
        if (done !== 1'b0)
        begin
            mismatches++;
            conclude();
        end
    endtask
    initial
    begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        xfer(16'h2000, 5'h10);
        check(got, 16'h0200);
        xfer(16'h2000, 5'h10);
        check(got, 16'h1000);
        $display("test power-up read done");
        for (b = 0; b < 8; b++)
        begin
            m = 8'h01 << b;
            detect <= m;
            repeat (12) @(posedge clk_in);
            detect <= 8'h00;
            repeat (12) @(posedge clk_in);
            check({15'h0000, fault}, {15'h0000, |(m & 8'hDF)});
            check({15'h0000, halt}, {15'h0000, |(m & 8'h5C)});
            xfer(16'h2000, 5'h10);
            check(got, {8'h10, m & 8'hDF});
            check({15'h0000, fault}, 16'h0000);
        end
        $display("test flag bits done");
        fork
            xfer(16'h2000, 5'h10);
            begin
                repeat (40) @(posedge clk_in);
                detect <= 8'h02;
                repeat (12) @(posedge clk_in);
                detect <= 8'h00;
            end
        join
        check(got, 16'h1000);
        check({15'h0000, fault}, 16'h0001);
        xfer(16'h2000, 5'h10);
        check(got, 16'h1002);
        $display("test shadow done");
        for (b = 0; b < 9; b++)
        begin
            xfer(cmds[b], 5'h10);
            check(got, resp[b]);
        end
        $display("test command codes done");
        xfer(16'h0400, 5'h0F);
        check(last_cmd, 16'h4000);
        xfer(16'h0400, 5'h11);
        check(last_cmd, 16'h4000);
        xfer(16'h2000, 5'h10);
        check(got, 16'h2000);
        check(last_cmd, 16'h2000);
        $display("test clock count done");
        conclude();
    end
endmodule

// ---- verification/ssdr_core_checker.sv ----
// Port checker for the responder, bound into ssdr_core.
// Assumes the bench runs clk_en_in high; select is async.
`timescale 1ns/1ps
module ssdr_core_checker
    import ssdr_pkg::*;
(
    // System
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic        clk_en_in,
    // Serial link
    input wire logic        sck_in,
    input wire logic        cs_n_in,
    input wire logic        sdi_in,
    input wire logic        sdo_out,
    input wire logic        sdo_oe_n_out,
    // Status
    input wire logic [7:0]  detect_in,
    input wire logic        fault_out,
    input wire logic        gate_halt_out,
    input wire logic [15:0] last_command_out
);
    // ----
    // Cycles since select rose, saturating
    // ----
    logic       cs_q_reg;
    logic [4:0] since_reg;
    logic [4:0] since_next;
    assign since_next = (cs_n_in && !cs_q_reg) ? 5'h00 :
                        (since_reg == 5'h1F) ? since_reg : since_reg + 5'h01;
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cs_q_reg  <= 1'b1;
            since_reg <= 5'h1F;
        end
        else
        begin
            cs_q_reg  <= cs_n_in;
            since_reg <= since_next;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    AST_OE_FOLLOWS_SELECT: assert property (sdo_oe_n_out == cs_n_in)
        else $error("output enable differs from select");
    AST_HALT_NEEDS_FAULT: assert property (gate_halt_out |-> fault_out)
        else $error("halt without fault");
    AST_SET_ON_DETECT: assert property ((clk_en_in && |(detect_in & FAULT_MASK)) [*8]
        |=> fault_out) else $error("held detector did not raise fault");
    AST_HALT_ON_DETECT: assert property ((clk_en_in && cs_n_in && since_reg > 5'h0C
        && |(detect_in & HALT_MASK)) [*8] |=> gate_halt_out) else $error("no halt");
    AST_FAULT_FALLS_AFTER_FRAME: assert property ($fell(fault_out) |-> since_reg < 5'h18)
        else $error("fault dropped outside a read");
    AST_FAULT_HELD_IN_FRAME: assert property (!cs_n_in && !$past(cs_n_in)
        |-> !$fell(fault_out)) else $error("fault dropped during frame");
    AST_CMD_ONLY_AFTER_FRAME: assert property ($changed(last_command_out)
        |-> since_reg < 5'h18) else $error("command changed outside frame end");
    AST_CMD_STEADY_IN_FRAME: assert property (!cs_n_in [*2] |-> $stable(last_command_out))
        else $error("command changed inside frame");
    cover property ($rose(fault_out));
    cover property ($rose(gate_halt_out));
    cover property ($changed(last_command_out));
endmodule

bind ssdr_core ssdr_core_checker u_checker (.clk_in(clk_in), .reset_in(reset_in),
    .clk_en_in(clk_en_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .sdi_in(sdi_in),
    .sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out), .detect_in(detect_in),
    .fault_out(fault_out), .gate_halt_out(gate_halt_out),
    .last_command_out(last_command_out));

// ---- verification/ssdr_host_model.sv ----
// Host model: serial master making one frame per request.
// Assumes a four-phase start/done handshake from the bench.
`timescale 1ns/1ps
module ssdr_host_model
(
    // Bench side
    input  wire logic        clk_in,
    input  wire logic        start_in,
    input  wire logic [15:0] word_in,
    input  wire logic [4:0]  pulses_in,
    output logic             done_out,
    output logic [15:0]      rx_out,
    // Serial link
    input  wire logic        sdo_in,
    output logic             sck_out,
    output logic             cs_n_out,
    output logic             sdi_out
);
    logic [15:0] sh;
    initial
    begin
        sck_out = 1'b1;
        cs_n_out = 1'b1;
        sdi_out = 1'b1;
        done_out = 1'b0;
        rx_out = 16'h0000;
        forever
        begin
            @(posedge clk_in iff start_in);
            sh = word_in;
            #7 cs_n_out = 1'b0;
            #120;
            repeat (pulses_in)
            begin
                sck_out = 1'b0;
                sdi_out = sh[15];
                sh = {sh[14:0], sh[15]};
                #40 sck_out = 1'b1;
                rx_out = {rx_out[14:0], sdo_in};
                #40;
            end
            #80 cs_n_out = 1'b1;
            // Pull-up level; gap lets the next word be prepared
            sdi_out = 1'b1;
            #1200 @(posedge clk_in);
            #1 done_out = 1'b1;
            @(posedge clk_in iff !start_in);
            #1 done_out = 1'b0;
        end
    end
endmodule
